// >>> hdl/hcs_pkg.sv
// types shared by the heater status bank modules
package hcs_pkg;
`include "hcs_regs.svh"

   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } hcs_apb_req_type;

   // apb answer to the master
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } hcs_apb_rsp_type;

   // one current sensor's inputs
   typedef struct packed {
      logic [`HCS_CUR_W-1:0] current;
      logic                  sample_valid;
      logic                  ctrl_on;
      logic                  connected;
      logic                  assign_en;
      logic                  heater_burnout_alarm;
      logic                  heater_short_alarm;
      logic                  over_current_alarm;
   } hcs_sense_type;

   // state of one sensor channel
   typedef struct packed {
      logic [`HCS_CNT_W-1:0] on_cnt;
      logic                  ctrl_prev;
      logic                  on_ok;
      logic                  hold;
      logic                  over_err;
      logic [`HCS_CUR_W-1:0] monitor;
   } hcs_chan_type;

   // state of the register bank
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic [15:0] irq_stat;
      logic [15:0] irq_mask;
      logic [15:0] lvl_prev;
      logic [5:0]  alarm;
      logic        irq;
   } hcs_bank_type;
endpackage

// >>> hdl/hcs_regs.svh
// offsets, field positions, reset values and timing counts of the heater status bank
`ifndef HCS_REGS_SVH
`define HCS_REGS_SVH

// clock rate and control output least ON time
`define HCS_CLK_MHZ       250
`define HCS_ON_MIN_MS     100
`define HCS_ON_MIN_CYCLES (`HCS_ON_MIN_MS * `HCS_CLK_MHZ * 1000)
`define HCS_CNT_W         25

// current in 0.1 A steps; 110.0 A limit
`define HCS_CUR_W         16
`define HCS_OVC_LIMIT     16'h044c

// register indices; byte address is four times the index
`define HCS_IDX_OVERCUR   6'h07
`define HCS_IDX_ALARM     6'h08
`define HCS_IDX_HOLD      6'h09
`define HCS_IDX_IRQ_STAT  6'h10
`define HCS_IDX_IRQ_MASK  6'h11
`define HCS_IDX_MON_ONE   6'h12
`define HCS_IDX_MON_TWO   6'h13

// field positions per sensor s: base + stride * s
`define HCS_OVC_STRIDE    1
`define HCS_ALM_STRIDE    4
`define HCS_HOLD_STRIDE   4
`define HCS_EV_OVC_BASE   0
`define HCS_EV_HOLD_BASE  2
`define HCS_EV_ALM_BASE   8

// reset values
`define HCS_RST_WORD      16'h0000
`define HCS_RST_DATA      32'h0000_0000

`endif

// >>> hdl/hcs_sensor.sv
// one current sensor channel: on-time check, hold flag, monitor value, overcurrent error
`timescale 1ns/100ps
`include "hcs_regs.svh"
module hcs_sensor #(
   parameter int unsigned ON_MIN_CYCLES = `HCS_ON_MIN_CYCLES
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // sensor side
   input  wire hcs_pkg::hcs_sense_type sense,
   // results
   output logic                        hold,
   output logic                        over_err,
   output logic [`HCS_CUR_W-1:0]       monitor
);
   import hcs_pkg::*;

   localparam logic [`HCS_CNT_W-1:0] MIN_C = ON_MIN_CYCLES[`HCS_CNT_W-1:0];

   hcs_chan_type s_q;
   hcs_chan_type s_d;
   logic         hold_now;

   // next state
   always_comb begin
      s_d           = s_q;
      s_d.ctrl_prev = sense.ctrl_on;
      // count the ON period, saturating at the least ON time
      if (sense.ctrl_on && !s_q.ctrl_prev) begin
         s_d.on_cnt = {{(`HCS_CNT_W-1){1'b0}}, 1'b1};
      end else if (sense.ctrl_on && s_q.on_cnt < MIN_C) begin
         s_d.on_cnt = s_q.on_cnt + 1'b1;
      end
      // period judged long once it reaches the limit, short if it ends early
      if (sense.ctrl_on && s_d.on_cnt >= MIN_C) begin
         s_d.on_ok = 1'b1;
      end else if (!sense.ctrl_on && s_q.ctrl_prev) begin
         s_d.on_ok = (s_q.on_cnt >= MIN_C);
      end
      hold_now = !s_d.on_ok || !sense.connected || !sense.assign_en;
      s_d.hold = hold_now;
      // the monitor only follows samples while not held
      if (sense.sample_valid && !hold_now) begin
         s_d.monitor = sense.current;
      end
      // error follows every sample, held or not
      if (sense.sample_valid) begin
         s_d.over_err = (sense.current > `HCS_OVC_LIMIT);
      end
   end

   // state register; hold set at reset since no ON period is known yet
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{on_cnt: '0, ctrl_prev: 1'b0, on_ok: 1'b0, hold: 1'b1,
                  over_err: 1'b0, monitor: `HCS_RST_WORD};
      end else begin
         s_q <= s_d;
      end
   end

   assign hold     = s_q.hold;
   assign over_err = s_q.over_err;
   assign monitor  = s_q.monitor;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_hold_missing: assert property (
      (!sense.connected || !sense.assign_en) |=> hold)
      else $error("hold not set for missing or disabled sensor");
   a_over_set: assert property (
      (sense.sample_valid && sense.current > `HCS_OVC_LIMIT) |=> over_err)
      else $error("overcurrent error not set");
   a_over_clr: assert property (
      (sense.sample_valid && sense.current <= `HCS_OVC_LIMIT) |=> !over_err)
      else $error("overcurrent error not cleared");
   a_mon_frozen: assert property (
      hold_now |=> $stable(monitor))
      else $error("monitor changed while held");
   a_short_on: assert property (
      (s_q.ctrl_prev && !sense.ctrl_on && s_q.on_cnt < MIN_C) |=> hold)
      else $error("short ON period did not hold");
   c_hold_short: cover property (s_q.ctrl_prev && !sense.ctrl_on && s_q.on_cnt < MIN_C);
   c_over_err: cover property ($rose(over_err));
endmodule

// >>> hdl/hcs_top.sv
// heater current status bank: apb slave, status words, sticky events, interrupt
// Notes on behaviour
// - sensor one above 110.0 A sets error bit 0
// - sensor two above 110.0 A sets error bit 1
// - sensor one alarms on bits 0 to 2
// - sensor two alarms on bits 4 to 6
// - short ON time holds sensor one, bit 0
// - missing or disabled sensor also holds
// - sensor two hold on bit 4, same causes
`timescale 1ns/100ps
`include "hcs_regs.svh"
module hcs_top #(
   parameter int unsigned ON_MIN_CYCLES = `HCS_ON_MIN_CYCLES,
   parameter int unsigned N_SENSE       = 2
) (
   // clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 reset_n,
   // apb slave
   input  wire hcs_pkg::hcs_apb_req_type             apb_req,
   output hcs_pkg::hcs_apb_rsp_type                  apb_rsp,
   // current sensors
   input  wire hcs_pkg::hcs_sense_type [N_SENSE-1:0] sense,
   // interrupt
   output logic                                      irq
);
   import hcs_pkg::*;

   // ==========================================================
   // sensor channels
   // ==========================================================
   logic [N_SENSE-1:0]                 over_w;
   logic [N_SENSE-1:0]                 hold_w;
   logic [N_SENSE-1:0][`HCS_CUR_W-1:0] mon_w;

   // one channel per current sensor
   for (genvar g = 0; g < N_SENSE; g++) begin : g_chan
      hcs_sensor #(
         .ON_MIN_CYCLES (ON_MIN_CYCLES)
      ) u_chan (
         .clk      (clk),
         .reset_n  (reset_n),
         .sense    (sense[g]),
         .hold     (hold_w[g]),
         .over_err (over_w[g]),
         .monitor  (mon_w[g])
      );
   end

   // ==========================================================
   // bank state
   // ==========================================================
   hcs_bank_type b_q;
   hcs_bank_type b_d;
   logic [15:0]  ovc_word;
   logic [15:0]  alm_word;
   logic [15:0]  hold_word;
   logic [15:0]  lvl;
   logic [15:0]  clr;
   logic [31:0]  rd;
   logic         bad;
   logic         access;
   logic         done;
   logic [5:0]   idx;

   // status words, events and the apb slave in one next-state process
   always_comb begin
      b_d       = b_q;
      ovc_word  = `HCS_RST_WORD;
      alm_word  = `HCS_RST_WORD;
      hold_word = `HCS_RST_WORD;
      lvl       = `HCS_RST_WORD;
      clr       = `HCS_RST_WORD;
      rd        = `HCS_RST_DATA;
      bad       = 1'b0;
      // alarms pass through one flop so the words come from registers
      for (int s = 0; s < N_SENSE; s++) begin
         b_d.alarm[3*s]   = sense[s].heater_burnout_alarm;
         b_d.alarm[3*s+1] = sense[s].heater_short_alarm;
         b_d.alarm[3*s+2] = sense[s].over_current_alarm;
      end
      // place each sensor's bits in the three words
      for (int s = 0; s < N_SENSE; s++) begin
         ovc_word[`HCS_OVC_STRIDE*s]    = over_w[s];
         alm_word[`HCS_ALM_STRIDE*s]    = b_q.alarm[3*s];
         alm_word[`HCS_ALM_STRIDE*s+1]  = b_q.alarm[3*s+1];
         alm_word[`HCS_ALM_STRIDE*s+2]  = b_q.alarm[3*s+2];
         hold_word[`HCS_HOLD_STRIDE*s]  = hold_w[s];
         lvl[`HCS_EV_OVC_BASE+s]        = over_w[s];
         lvl[`HCS_EV_HOLD_BASE+s]       = hold_w[s];
         lvl[`HCS_EV_ALM_BASE+4*s]      = b_q.alarm[3*s];
         lvl[`HCS_EV_ALM_BASE+4*s+1]    = b_q.alarm[3*s+1];
         lvl[`HCS_EV_ALM_BASE+4*s+2]    = b_q.alarm[3*s+2];
      end
      // apb: one wait state, answer in the second access cycle
      access = apb_req.psel && apb_req.penable;
      done   = access && b_q.pready;
      idx    = apb_req.paddr[7:2];
      case (idx)
         `HCS_IDX_OVERCUR:  rd[15:0] = ovc_word;
         `HCS_IDX_ALARM:    rd[15:0] = alm_word;
         `HCS_IDX_HOLD:     rd[15:0] = hold_word;
         `HCS_IDX_IRQ_STAT: rd[15:0] = b_q.irq_stat;
         `HCS_IDX_IRQ_MASK: rd[15:0] = b_q.irq_mask;
         `HCS_IDX_MON_ONE:  rd[15:0] = mon_w[0];
         `HCS_IDX_MON_TWO:  rd[15:0] = mon_w[N_SENSE-1];
         default:           bad      = 1'b1;
      endcase
      if (apb_req.paddr[1:0] != 2'b00) begin
         bad = 1'b1;
      end
      b_d.pready  = access && !b_q.pready;
      b_d.pslverr = access && !b_q.pready && bad;
      b_d.prdata  = (access && !b_q.pready && !apb_req.pwrite && !bad) ?
                    rd : `HCS_RST_DATA;
      // writes reach only the event registers; status words ignore them
      if (done && apb_req.pwrite && !bad) begin
         if (idx == `HCS_IDX_IRQ_STAT) begin
            clr = apb_req.pwdata[15:0];
         end
         if (idx == `HCS_IDX_IRQ_MASK) begin
            b_d.irq_mask = apb_req.pwdata[15:0];
         end
      end
      // rising levels set sticky bits; a set beats a same-cycle clear
      b_d.lvl_prev = lvl;
      b_d.irq_stat = (b_q.irq_stat & ~clr) | (lvl & ~b_q.lvl_prev);
      b_d.irq      = |(b_d.irq_stat & b_d.irq_mask);
   end

   // lvl_prev starts with hold set so the reset hold makes no event
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         b_q <= '{pready: 1'b0, prdata: `HCS_RST_DATA, pslverr: 1'b0,
                  irq_stat: `HCS_RST_WORD, irq_mask: `HCS_RST_WORD,
                  lvl_prev: 16'h000c, alarm: '0, irq: 1'b0};
      end else begin
         b_q <= b_d;
      end
   end

   assign apb_rsp.pready  = b_q.pready;
   assign apb_rsp.prdata  = b_q.prdata;
   assign apb_rsp.pslverr = b_q.pslverr;
   assign irq             = b_q.irq;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // helpers: a read or a write that the slave takes without refusing it
   logic rd_go;
   logic wr_go;
   assign rd_go = access && !b_q.pready && !apb_req.pwrite && !bad;
   assign wr_go = done && apb_req.pwrite && !bad;

   a_rd_answer: assert property (
      (access && !b_q.pready) |=> apb_rsp.pready)
      else $error("apb answer missing");
   a_ovc_read: assert property (
      (access && !b_q.pready && !apb_req.pwrite && idx == `HCS_IDX_OVERCUR
       && apb_req.paddr[1:0] == 2'b00)
      |=> apb_rsp.prdata[0] == $past(over_w[0]) && apb_rsp.prdata[31:2] == '0)
      else $error("overcurrent word read wrong");
   a_alm_unused: assert property (
      (access && !b_q.pready && idx == `HCS_IDX_ALARM)
      |=> apb_rsp.prdata[3] == 1'b0 && apb_rsp.prdata[31:7] == '0)
      else $error("alarm word unused bits set");
   a_alm_map: assert property (
      (access && !b_q.pready && !apb_req.pwrite && idx == `HCS_IDX_ALARM
       && apb_req.paddr[1:0] == 2'b00)
      |=> apb_rsp.prdata[2:0] == $past(b_q.alarm[2:0]))
      else $error("sensor one alarms misplaced");
   a_hold_read: assert property (
      (access && !b_q.pready && !apb_req.pwrite && idx == `HCS_IDX_HOLD
       && apb_req.paddr[1:0] == 2'b00)
      |=> apb_rsp.prdata[4] == $past(hold_w[N_SENSE-1])
          && apb_rsp.prdata[3:1] == 3'b000 && apb_rsp.prdata[31:5] == '0)
      else $error("hold word read wrong");
   a_ro_write: assert property (
      (done && apb_req.pwrite && idx == `HCS_IDX_HOLD) |=> $stable(b_q.irq_mask))
      else $error("write to status word had an effect");
   a_set_wins: assert property (
      (lvl[0] && !b_q.lvl_prev[0]) |=> b_q.irq_stat[0])
      else $error("event lost against clear");
   a_irq_gate: assert property (
      (b_q.irq_stat & b_q.irq_mask) == 16'h0000 |-> !irq)
      else $error("interrupt without unmasked event");

   // ==========================================================
   // bus protocol checks
   // ==========================================================
   // answer is a one-cycle pulse so the master cannot take it twice
   a_ready_pulse: assert property (
      apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
   a_ready_idle: assert property (
      !access |=> !apb_rsp.pready)
      else $error("pready without an access");
   // data bus rests at zero so stale words never leak out
   a_rdata_idle: assert property (
      !apb_rsp.pready |-> apb_rsp.prdata == 32'h0000_0000)
      else $error("read data outside the answer");
   a_err_ready: assert property (
      apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000)
      else $error("error flag outside the answer or with data");
   a_err_bad: assert property (
      (access && !b_q.pready && bad) |=> apb_rsp.pslverr)
      else $error("bad address not refused");
   a_err_good: assert property (
      (access && !b_q.pready && !bad) |=> !apb_rsp.pslverr)
      else $error("good address refused");
   // status words take writes silently, with no error
   a_ro_no_err: assert property (
      (done && apb_req.pwrite && apb_req.paddr[1:0] == 2'b00
       && (idx == `HCS_IDX_OVERCUR || idx == `HCS_IDX_ALARM || idx == `HCS_IDX_HOLD))
      |-> !apb_rsp.pslverr)
      else $error("write to status word refused");

   // ==========================================================
   // status word checks
   // ==========================================================
   // both sensors' bits sit at fixed places; the overcurrent and monitor checks take the last channel, N_SENSE-1, as sensor two, the alarm check takes alarm[5:3]
   a_ovc_two: assert property (
      (rd_go && idx == `HCS_IDX_OVERCUR)
      |=> apb_rsp.prdata[1] == $past(over_w[N_SENSE-1]))
      else $error("sensor two overcurrent misplaced");
   a_alm_two: assert property (
      (rd_go && idx == `HCS_IDX_ALARM)
      |=> apb_rsp.prdata[6:4] == $past(b_q.alarm[5:3]))
      else $error("sensor two alarms misplaced");
   a_hold_one: assert property (
      (rd_go && idx == `HCS_IDX_HOLD)
      |=> apb_rsp.prdata[0] == $past(hold_w[0]))
      else $error("sensor one hold misplaced");
   a_mon_one: assert property (
      (rd_go && idx == `HCS_IDX_MON_ONE)
      |=> apb_rsp.prdata[15:0] == $past(mon_w[0]) && apb_rsp.prdata[31:16] == 16'h0000)
      else $error("sensor one monitor read wrong");
   a_mon_two: assert property (
      (rd_go && idx == `HCS_IDX_MON_TWO)
      |=> apb_rsp.prdata[15:0] == $past(mon_w[N_SENSE-1]))
      else $error("sensor two monitor read wrong");
   // causes seen from the bank side, one cycle to the flag
   a_hold_src_one: assert property (
      (!sense[0].connected || !sense[0].assign_en) |=> hold_w[0])
      else $error("sensor one not held when missing");
   a_hold_src_two: assert property (
      (!sense[1].connected || !sense[1].assign_en) |=> hold_w[1])
      else $error("sensor two not held when missing");
   a_ovc_src_one: assert property (
      (sense[0].sample_valid && sense[0].current > `HCS_OVC_LIMIT) |=> over_w[0])
      else $error("sensor one overcurrent not flagged");
   a_alm_flop: assert property (
      1'b1 |=> b_q.alarm[0] == $past(sense[0].heater_burnout_alarm))
      else $error("sensor one burnout alarm not registered");

   // ==========================================================
   // event and interrupt checks
   // ==========================================================
   a_mask_write: assert property (
      (wr_go && idx == `HCS_IDX_IRQ_MASK) |=> b_q.irq_mask == $past(apb_req.pwdata[15:0]))
      else $error("mask write lost");
   a_mask_read: assert property (
      (rd_go && idx == `HCS_IDX_IRQ_MASK) |=> apb_rsp.prdata[15:0] == $past(b_q.irq_mask))
      else $error("mask read wrong");
   a_stat_read: assert property (
      (rd_go && idx == `HCS_IDX_IRQ_STAT) |=> apb_rsp.prdata[15:0] == $past(b_q.irq_stat))
      else $error("event status read wrong");
   // a one clears unless a new rise lands in the same cycle
   a_stat_clear: assert property (
      (wr_go && idx == `HCS_IDX_IRQ_STAT && apb_req.pwdata[0]
       && !(lvl[0] && !b_q.lvl_prev[0])) |=> !b_q.irq_stat[0])
      else $error("event not cleared by write of one");
   a_stat_sticky: assert property (
      (b_q.irq_stat[0] && !(wr_go && idx == `HCS_IDX_IRQ_STAT && apb_req.pwdata[0]))
      |=> b_q.irq_stat[0])
      else $error("event bit dropped without clear");
   a_hold_event: assert property (
      (lvl[2] && !b_q.lvl_prev[2]) |=> b_q.irq_stat[2])
      else $error("hold rise not recorded");
   a_alm_event: assert property (
      (lvl[8] && !b_q.lvl_prev[8]) |=> b_q.irq_stat[8])
      else $error("alarm rise not recorded");
   // places with no event source must never latch
   a_stat_spare: assert property (
      (b_q.irq_stat & 16'h88f0) == 16'h0000)
      else $error("unused event bit set");
   a_irq_raise: assert property (
      (b_q.irq_stat & b_q.irq_mask) != 16'h0000 |-> irq)
      else $error("unmasked event without interrupt");
   a_irq_off: assert property (
      (wr_go && idx == `HCS_IDX_IRQ_MASK && apb_req.pwdata[15:0] == 16'h0000) |=> !irq)
      else $error("interrupt stays up after full mask");
   c_rd_hold: cover property (done && !apb_req.pwrite && idx == `HCS_IDX_HOLD);
   c_irq: cover property ($rose(irq));
   c_clear: cover property (done && apb_req.pwrite && idx == `HCS_IDX_IRQ_STAT);
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the heater current status bank
`timescale 1ns/100ps
`include "hcs_regs.svh"
module tb_top;
   import hcs_pkg::*;
   // ==========
   // clock, reset and design
   localparam int unsigned ON_MIN = 20; // short on-time limit keeps the run brief
   logic                clk;
   logic                reset_n;
   hcs_apb_req_type     apb_req;
   hcs_apb_rsp_type     apb_rsp;
   hcs_sense_type [1:0] sense;
   logic                irq;
   int                  error_cnt;
   int                  checks_done;
   logic [31:0]         mon [2];
   logic [5:0]          ro_idx [3];

   hcs_top #(.ON_MIN_CYCLES(ON_MIN), .N_SENSE(2)) hcs_top_inst (
      .clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .sense(sense), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========
   // verdict and compare
   task automatic report_and_stop();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ==========
   // apb master: request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      logic rdy = 1'b0;
      int   n = 0;
      @(posedge clk);
      apb_req.psel   <= 1'b1;
      apb_req.pwrite <= wr;
      apb_req.paddr  <= {idx, 2'b00};
      apb_req.pwdata <= wd;
      @(posedge clk);
      apb_req.penable <= 1'b1;
      // answer, data and error are all taken at the rising edge that shows pready
      while (!rdy && n < 50) begin
         @(posedge clk);
         rdy = (apb_rsp.pready === 1'b1);
         rd  = apb_rsp.prdata;
         err = apb_rsp.pslverr;
         n++;
      end
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      if (!rdy) begin
         chk("pready", 32'h0000_0001, 32'h0000_0000);
      end
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp,
                         input logic eerr = 1'b0);
      logic [31:0] d;
      logic        e;
      apb(1'b0, idx, 32'h0000_0000, d, e);
      chk($sformatf("reg %h", idx), exp, d);
      chk("pslverr", {31'b0, eerr}, {31'b0, e});
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] v);
      logic [31:0] d;
      logic        e;
      apb(1'b1, idx, v, d, e);
      chk("write pslverr", 32'h0000_0000, {31'b0, e});
   endtask

   // ==========
   // sensor stimulus
   task automatic sample(input int s, input logic [15:0] v);
      @(posedge clk);
      sense[s].current      <= v;
      sense[s].sample_valid <= 1'b1;
      @(posedge clk);
      sense[s].sample_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic on_period(input logic [1:0] m, input int n);
      @(posedge clk);
      sense[0].ctrl_on <= m[0];
      sense[1].ctrl_on <= m[1];
      repeat (n) @(posedge clk);
      sense[0].ctrl_on <= 1'b0;
      sense[1].ctrl_on <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("irq", {31'b0, e}, {31'b0, irq});
   endtask

   // ==========
   // watchdog: the sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   // ==========
   // test sequence
   initial begin
      error_cnt   = 0;
      checks_done = 0;
      reset_n     = 1'b0;
      apb_req     = '0;
      sense       = '0;
      ro_idx      = '{`HCS_IDX_OVERCUR, `HCS_IDX_ALARM, `HCS_IDX_HOLD};
      for (int s = 0; s < 2; s++) begin
         sense[s].connected = 1'b1;
         sense[s].assign_en = 1'b1;
      end
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      // no on period judged yet, so both monitors start held
      rd_chk(`HCS_IDX_OVERCUR, 32'h0000_0000);
      rd_chk(`HCS_IDX_ALARM, 32'h0000_0000);
      rd_chk(`HCS_IDX_HOLD, 32'h0000_0011);
      on_period(2'b11, ON_MIN + 5);
      rd_chk(`HCS_IDX_HOLD, 32'h0000_0000);
      // limit itself is not an error, one step above it is
      sample(0, 16'h044d);
      sample(1, 16'h044c);
      rd_chk(`HCS_IDX_OVERCUR, 32'h0000_0001);
      sample(0, 16'h044c);
      sample(1, 16'h044d);
      rd_chk(`HCS_IDX_OVERCUR, 32'h0000_0002);
      mon[0] = 32'h0000_044c;
      mon[1] = 32'h0000_044d;
      rd_chk(`HCS_IDX_MON_ONE, mon[0]);
      rd_chk(`HCS_IDX_MON_TWO, mon[1]);
      // each hold cause per sensor: unplugged, disabled, short on time
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            if (c == 0) sense[s].connected <= 1'b0;
            if (c == 1) sense[s].assign_en <= 1'b0;
            if (c == 2) on_period(2'b01 << s, 5);
            sample(s, 16'h0123);
            rd_chk(`HCS_IDX_HOLD, 32'h1 << (4 * s));
            rd_chk(6'(`HCS_IDX_MON_ONE + s), mon[s]);
            @(posedge clk);
            sense[s].connected <= 1'b1;
            sense[s].assign_en <= 1'b1;
            on_period(2'b11, ON_MIN + 5);
            rd_chk(`HCS_IDX_HOLD, 32'h0000_0000);
         end
      end
      // alarm fields are the three low bits of the sensor struct
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         sense[k / 3][2 - k % 3] <= 1'b1;
         repeat (3) @(posedge clk);
         rd_chk(`HCS_IDX_ALARM, 32'h1 << (4 * (k / 3) + k % 3));
         @(posedge clk);
         sense[k / 3][2 - k % 3] <= 1'b0;
      end
      // status words ignore writes; unmapped place is refused
      for (int i = 0; i < 3; i++) begin
         wr(ro_idx[i], 32'hffff_ffff);
         rd_chk(ro_idx[i], 32'h0000_0000);
      end
      rd_chk(6'h3f, 32'h0000_0000, 1'b1);
      // sticky event, mask and write-one-to-clear
      wr(`HCS_IDX_IRQ_STAT, 32'h0000_ffff);
      wr(`HCS_IDX_IRQ_MASK, 32'h0000_0001);
      rd_chk(`HCS_IDX_IRQ_STAT, 32'h0000_0000);
      sample(0, 16'h044d);
      irq_chk(1'b1);
      rd_chk(`HCS_IDX_IRQ_STAT, 32'h0000_0001);
      wr(`HCS_IDX_IRQ_MASK, 32'h0000_0000);
      irq_chk(1'b0);
      wr(`HCS_IDX_IRQ_MASK, 32'h0000_0001);
      irq_chk(1'b1);
      wr(`HCS_IDX_IRQ_STAT, 32'h0000_0001);
      irq_chk(1'b0);
      rd_chk(`HCS_IDX_IRQ_STAT, 32'h0000_0000);
      rd_chk(`HCS_IDX_OVERCUR, 32'h0000_0001);
      report_and_stop();
   end
endmodule
